// file: verification/ccr_chk.sv
// Checker for the charger configuration bank, bound to its top module.
// Sees only the top ports; every check is sampled on mclk.
`timescale 1ns/10ps
module ccr_chk (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire ccr_pkg::cfg_t cfg,
	input wire logic wdog_fault
);
	logic up_d;
	logic up_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// ==========
	// Settings appear one edge after release, so that edge is skipped
	always_comb up_d = 1'b1;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			up_q <= 1'b0;
		else
			up_q <= up_d;
	end
	sequence s_fault_up;
		$rose(wdog_fault);
	endsequence
	a_scl_o_low: assert property (scl_o == 1'b0) else $error("scl_o driven high");
	a_sda_o_low: assert property (sda_o == 1'b0) else $error("sda_o driven high");
	a_sda_scl_low: assert property ($rose(sda_oe) |-> !scl_i) else $error("sda pulled, scl high");
	a_mode_exclusive: assert property (!(cfg.charge_enable && cfg.otg_enable))
		else $error("charge and boost both on");
	a_vsys_range: assert property (up_q |-> cfg.min_system_voltage inside {[13'hBB8:13'hE74]})
		else $error("min system voltage out of range");
	a_ichg_range: assert property (up_q |-> cfg.fast_charge_current inside {[13'h200:13'h11C0]})
		else $error("fast charge current out of range");
	a_ipre_range: assert property (up_q |-> cfg.precharge_current inside {[13'h40:13'h400]})
		else $error("precharge current out of range");
	a_iterm_range: assert property (up_q |-> cfg.termination_current inside {[13'h40:13'h400]})
		else $error("termination current out of range");
	a_vfull_range: assert property (up_q |-> cfg.full_charge_voltage inside {[13'hD98:13'h1149]})
		else $error("full charge voltage out of range");
	a_timer_hours: assert property (up_q |-> cfg.cc_timer_select inside
		{6'h05, 6'h08, 6'h0C, 6'h14, 6'h0A, 6'h10, 6'h18, 6'h28}) else $error("bad timer hours");
	a_fault_sticky: assert property (s_fault_up |=> wdog_fault [*8])
		else $error("watchdog fault dropped early");
endmodule : ccr_chk
bind ccr_charger_config_registers ccr_chk chk_i (.mclk(mclk), .reset_n(reset_n), .scl_i(scl_i),
	.scl_o(scl_o), .sda_o(sda_o), .sda_oe(sda_oe), .cfg(cfg), .wdog_fault(wdog_fault));

// file: verification/ccr_host_model.sv
// Host model: master of the two-wire port with behavioural timing.
// Assumes the bench resolves both open-drain wires with pull-ups.
`timescale 1ns/10ps
module ccr_host_model (
	input wire logic scl,
	input wire logic sda,
	output logic scl_low,
	output logic sda_low
);
	localparam time Q = 60ns;
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	// ==========
	// Release SCL, honour stretching by the slave, bounded wait
	task automatic rise();
		scl_low = 1'b0;
		for (int i = 0; i < 300 && !scl; i++) #4;
		#Q;
	endtask : rise
	// One bit: data set while SCL low, sampled mid high
	task automatic bit_io(input logic b, output logic s);
		sda_low = !b;
		#Q;
		rise();
		s = sda;
		#Q;
		scl_low = 1'b1;
		#Q;
	endtask : bit_io
	task automatic st();
		sda_low = 1'b0;
		#Q;
		rise();
		sda_low = 1'b1;
		#Q;
		scl_low = 1'b1;
		#Q;
	endtask : st
	task automatic sp();
		sda_low = 1'b1;
		#Q;
		rise();
		sda_low = 1'b0;
		#Q;
	endtask : sp
	// MSB first, then the ninth clock; last high releases SDA
	task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q,
		output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(last, s);
		ack = !s;
	endtask : byte_io
	task automatic wr(input logic [7:0] r, input logic [7:0] d[$], output logic ok);
		logic [7:0] q;
		logic a;
		st();
		byte_io({ccr_pkg::DEV_ADDR, 1'b0}, 1'b1, q, ok);
		byte_io(r, 1'b1, q, a);
		ok &= a;
		// Stop sending once refused, the slave has gone idle
		foreach (d[i]) begin
			if (ok)
				byte_io(d[i], 1'b1, q, ok);
		end
		sp();
	endtask : wr
	task automatic rd(input logic [7:0] r, input int n, output logic [7:0] q[$],
		output logic ok);
		logic [7:0] b;
		logic a;
		q = {};
		st();
		byte_io({ccr_pkg::DEV_ADDR, 1'b0}, 1'b1, b, ok);
		byte_io(r, 1'b1, b, a);
		ok &= a;
		st();
		byte_io({ccr_pkg::DEV_ADDR, 1'b1}, 1'b1, b, a);
		ok &= a;
		for (int i = 0; i < n; i++) begin
			byte_io(8'hFF, i == n - 1, b, a);
			q.push_back(b);
		end
		sp();
	endtask : rd
endmodule : ccr_host_model

// file: verification/tb.sv
// Bench for the charger configuration bank: host model on the wires,
// readback and decoded settings compared with values worked out here.
`timescale 1ns/10ps
module tb;
	localparam int unsigned SEC = 25;
	logic mclk = 1'b0;
	logic lclk = 1'b0;
	logic reset_n = 1'b0;
	logic ppl = 1'b0;
	logic scl_oe, sda_oe, m_scl, m_sda, scl_w, sda_w, wdog_fault;
	ccr_pkg::cfg_t cfg;
	logic [7:0] rv [1:5];
	int bad_count = 0;
	int checked = 0;
	// ==========
	// Open-drain wires with pull-ups
	assign scl_w = !(scl_oe | m_scl);
	assign sda_w = !(sda_oe | m_sda);
	always #2 mclk = ~mclk;
	initial begin
		#1.3;
		forever #6 lclk = ~lclk;
	end
	ccr_charger_config_registers #(.SEC_CYCLES(SEC)) ccr_charger_config_registers_i (
		.mclk(mclk), .reset_n(reset_n), .lclk(lclk), .scl_i(scl_w), .sda_i(sda_w),
		.power_path_limiting(ppl), .scl_o(), .scl_oe(scl_oe), .sda_o(), .sda_oe(sda_oe),
		.cfg(cfg), .wdog_fault(wdog_fault));
	ccr_host_model ccr_host_model_i (.scl(scl_w), .sda(sda_w), .scl_low(m_scl),
		.sda_low(m_sda));
	task automatic chk(input logic [79:0] g, input logic [79:0] e);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// Expected settings decoded from the register image
	function automatic ccr_pkg::cfg_t ex();
		ccr_pkg::cfg_t c;
		logic [5:0] h [4] = '{6'h05, 6'h08, 6'h0C, 6'h14};
		c.charge_enable = rv[1][5:4] == 2'h1;
		c.otg_enable = rv[1][5];
		c.min_system_voltage = 13'hBB8 + 13'h64 * rv[1][3:1];
		c.system_headroom_select = rv[1][0];
		c.fast_charge_current = 13'h200 + 13'h40 * rv[2][7:2];
		c.boost_output_current_limit = rv[2][1:0] != 2'h0;
		c.precharge_current = 13'h40 + 13'h40 * rv[3][7:4];
		c.termination_current = 13'h40 + 13'h40 * rv[3][3:0];
		c.full_charge_voltage = 13'hD98 + 13'hF * rv[4][7:2];
		c.precharge_exit_threshold = rv[4][1];
		c.recharge_offset = rv[4][0];
		c.termination_enable = rv[5][7];
		c.done_indicator_early = rv[5][6];
		c.safety_timer_enable = rv[5][3];
		c.cc_timer_select = h[rv[5][2:1]] << ppl;
		return c;
	endfunction : ex
	task automatic dflt();
		rv = '{8'h1B, 8'h21, 8'h33, 8'hC3, 8'h98};
	endtask : dflt
	// Write through the host and track what the bank should hold
	task automatic wr(input logic [7:0] r, input logic [7:0] d[$], input logic ok_e);
		logic ok;
		ccr_host_model_i.wr(r, d, ok);
		chk(ok, ok_e);
		foreach (d[i]) begin
			if (r + i == 1 && d[i][7])
				dflt();
			else if (r + i inside {[1:5]})
				rv[r + i] = d[i] & (r + i == 1 ? 8'h3F : r + i == 5 ? 8'hFE : 8'hFF);
		end
	endtask : wr
	task automatic cfgchk();
		repeat (8) @(negedge mclk);
		chk(cfg, ex());
	endtask : cfgchk
	task automatic verify();
		logic [7:0] q[$];
		logic ok;
		ccr_host_model_i.rd(8'h01, 5, q, ok);
		chk(ok, 1'b1);
		foreach (q[i]) chk(q[i], rv[i + 1]);
		cfgchk();
	endtask : verify
	task automatic t_fields();
		wr(8'h01, {8'h2E, 8'hFE, 8'hF0, 8'hFC, 8'h47}, 1'b1);
		verify();
	endtask : t_fields
	task automatic t_ppl();
		@(negedge mclk);
		ppl = 1'b1;
		cfgchk();
		ppl = 1'b0;
		cfgchk();
	endtask : t_ppl
	// Every mode code and every boost limit code
	task automatic t_modes();
		for (int m = 0; m < 4; m++) begin
			wr(8'h01, {{2'h0, 2'(m), 4'hB}, {6'h08, 2'(m)}}, 1'b1);
			cfgchk();
		end
	endtask : t_modes
	// Each period code: restart clears fault, expiry lands on time
	task automatic t_wdog();
		int n;
		for (int c = 3; c >= 0; c--) begin
			wr(8'h05, {{2'h2, 2'(c), 4'h8}}, 1'b1);
			wr(8'h01, {rv[1] | 8'h40}, 1'b1);
			chk(wdog_fault, 1'b0);
			n = c == 0 ? 5000 : (20 << c) * SEC - 300;
			repeat (n) @(negedge mclk);
			chk(wdog_fault, 1'b0);
			if (c != 0) begin
				for (int i = 0; i < 600 && wdog_fault !== 1'b1; i++) @(negedge mclk);
				chk(wdog_fault, 1'b1);
			end
		end
		verify();
	endtask : t_wdog
	task automatic t_regrst();
		wr(8'h01, {8'h80}, 1'b1);
		verify();
	endtask : t_regrst
	task automatic t_undef();
		wr(8'h0B, {8'h55}, 1'b0);
		verify();
	endtask : t_undef
	task automatic end_of_test();
		if (bad_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	// ==========
	// Main sequence
	initial begin
		repeat (3) @(negedge mclk);
		reset_n = 1'b1;
		repeat (20) @(negedge mclk);
		dflt();
		verify();
		t_fields();
		t_ppl();
		t_modes();
		t_wdog();
		t_regrst();
		t_undef();
		end_of_test();
	end
	// Watchdog: the run needs about 250 us
	initial begin
		#380us;
		bad_count++;
		end_of_test();
	end
endmodule : tb

// file: verilog/ccr_charger_config_registers.sv
// Charger configuration register bank with its two-wire serial slave.
// Serial logic runs on lclk and oversamples the bus pins; the bank
// runs on mclk. Pins are open drain, resolved outside this module.
`timescale 1ns/10ps

// Functional notes
// - Writing bit 7 of reg 0x01 restores every register; bit reads 0.
// - Mode 00 disables charging, 01 charges, 10/11 select boost output.
// - Minimum system voltage is 3000 mV plus 100 mV per code step.
// - Bit 0 of reg 0x01 selects 50 or 100 mV headroom.
// - Fast charge current is 512 mA plus 64 mA per code step.
// - Boost current limit code 00 is 500 mA, 01 is 1.3 A.
// - Pre-charge current is 64 mA plus 64 mA per code step.
// - Termination current is 64 mA plus 64 mA per code step.
// - Full charge voltage is 3480 mV plus 15 mV per step.
// - Bit 1 of reg 0x04 picks 2.8 V or 3.0 V pre-charge exit.
// - Bit 0 of reg 0x04 picks 200 mV or 100 mV recharge offset.
// - Bit 7 of reg 0x05 enables charge termination.
// - Bit 6 of reg 0x05 gives early charge-done indication.
// - Watchdog code 00 off, else 40, 80 or 160 seconds.
// - Safety timer enable; 5/8/12/20 hours, doubled under power path limiting.
// - Resets 0x1B, 0x21, 0x33, 0xC3, 0x98; reg 0x05 bit 0 reserved zero.
// - Burst reads and writes advance the register address automatically.
// - Undefined register address gets a not-acknowledge and idle port.
// - Watchdog expiry without restart sets the watchdog fault flag.
module ccr_charger_config_registers #(
	parameter int unsigned SEC_CYCLES = ccr_pkg::SEC_CYCLES_DEF
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic lclk,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic power_path_limiting,
	output logic scl_o,
	output logic scl_oe,
	output logic sda_o,
	output logic sda_oe,
	output ccr_pkg::cfg_t cfg,
	output logic wdog_fault
);
	// =========================================================
	// Shared helpers
	function automatic logic [12:0] lin(input logic [5:0] code, input logic [7:0] step,
			input logic [12:0] ofs);
		lin = ofs + 13'(step * code);
	endfunction : lin

	function automatic logic [7:0] wdog_secs(input logic [1:0] code);
		unique case (code)
			2'h1: wdog_secs = ccr_pkg::WDOG_S_1;
			2'h2: wdog_secs = ccr_pkg::WDOG_S_2;
			2'h3: wdog_secs = ccr_pkg::WDOG_S_3;
			default: wdog_secs = 8'h00;
		endcase
	endfunction : wdog_secs

	// =========================================================
	// Link domain: pin synchronisers
	logic [1:0] scl_sy_q, sda_sy_q;
	logic scl_p_q, sda_p_q;
	logic scl_s, sda_s, scl_rise, scl_fall, bus_start, bus_stop;

	// Two flops per pin; edge history taken only from the second flop
	always_ff @(posedge lclk or negedge reset_n) begin
		if (!reset_n) begin
			scl_sy_q <= 2'h3;
			sda_sy_q <= 2'h3;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_sy_q <= {scl_sy_q[0], scl_i};
			sda_sy_q <= {sda_sy_q[0], sda_i};
			scl_p_q <= scl_sy_q[1];
			sda_p_q <= sda_sy_q[1];
		end
	end

	// Bus events; start and stop are SDA edges while SCL stays high
	assign scl_s = scl_sy_q[1];
	assign sda_s = sda_sy_q[1];
	assign scl_rise = scl_s & ~scl_p_q;
	assign scl_fall = ~scl_s & scl_p_q;
	assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign bus_stop = scl_s & scl_p_q & ~sda_p_q & sda_s;

	// =========================================================
	// Link domain: serial slave state machine
	ccr_pkg::st_t st_q, st_d;
	ccr_pkg::ph_t ph_q, ph_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] sr_q, sr_d, ptr_q, ptr_d, wr_addr_q, wr_addr_d, wr_data_q, wr_data_d;
	logic rw_q, rw_d, ackd_q, ackd_d;
	logic wr_tgl_q, wr_tgl_d, rd_tgl_q, rd_tgl_d;
	logic [1:0] rdack_sy_q;
	logic rdack_p_q, rd_done;
	logic rdack_tgl_q, rdack_tgl_d;
	logic [7:0] rd_data_q, rd_data_d;
	logic ld_q, ld_d; // Read byte sits in the shifter, SCL still held

	assign rd_done = rdack_sy_q[1] ^ rdack_p_q;

	// Next state; a start or stop overrides whatever byte is in flight
	always_comb begin
		st_d = st_q;
		ph_d = ph_q;
		cnt_d = cnt_q;
		sr_d = sr_q;
		ptr_d = ptr_q;
		rw_d = rw_q;
		ackd_d = ackd_q;
		wr_tgl_d = wr_tgl_q;
		rd_tgl_d = rd_tgl_q;
		wr_addr_d = wr_addr_q;
		wr_data_d = wr_data_q;
		ld_d = rd_done;
		unique case (st_q)
			ccr_pkg::ST_IDLE: begin
			end
			ccr_pkg::ST_RX: begin
				if (scl_rise) begin
					sr_d = {sr_q[6:0], sda_s};
					cnt_d = 4'(cnt_q + 4'h1);
				end else if (scl_fall && cnt_q == ccr_pkg::BITS_PER_BYTE) begin
					cnt_d = 4'h0;
					unique case (ph_q)
						ccr_pkg::PH_ADDR: begin
							if (sr_q[7:1] == ccr_pkg::DEV_ADDR) begin
								st_d = ccr_pkg::ST_ACK;
								rw_d = sr_q[0];
								ph_d = ccr_pkg::PH_REG;
							end else begin
								st_d = ccr_pkg::ST_IDLE;
							end
						end
						ccr_pkg::PH_REG: begin
							if (sr_q <= ccr_pkg::ADDR_LAST_DEF) begin
								ptr_d = sr_q;
								ph_d = ccr_pkg::PH_DATA;
								st_d = ccr_pkg::ST_ACK;
							end else begin
								st_d = ccr_pkg::ST_IDLE;
							end
						end
						default: begin
							if (ptr_q <= ccr_pkg::ADDR_LAST_DEF) begin
								wr_addr_d = ptr_q;
								wr_data_d = sr_q;
								wr_tgl_d = ~wr_tgl_q;
								ptr_d = 8'(ptr_q + 8'h01);
								st_d = ccr_pkg::ST_ACK;
							end else begin
								st_d = ccr_pkg::ST_IDLE;
							end
						end
					endcase
				end
			end
			ccr_pkg::ST_ACK: begin
				if (scl_fall) begin
					cnt_d = 4'h0;
					if (rw_q) begin
						st_d = ccr_pkg::ST_FETCH;
						rd_tgl_d = ~rd_tgl_q;
					end else begin
						st_d = ccr_pkg::ST_RX;
					end
				end
			end
			ccr_pkg::ST_FETCH: begin
				// SCL is held low until the bank answers and one cycle more,
				// so the first bit is on SDA before SCL is let go
				if (rd_done) begin
					sr_d = rd_data_q;
				end
				if (ld_q) begin
					st_d = ccr_pkg::ST_TX;
					cnt_d = 4'h0;
				end
			end
			ccr_pkg::ST_TX: begin
				if (scl_rise) begin
					cnt_d = 4'(cnt_q + 4'h1);
				end else if (scl_fall) begin
					if (cnt_q == ccr_pkg::BITS_PER_BYTE) begin
						st_d = ccr_pkg::ST_MACK;
					end else begin
						sr_d = {sr_q[6:0], 1'b0};
					end
				end
			end
			ccr_pkg::ST_MACK: begin
				if (scl_rise) begin
					ackd_d = ~sda_s;
				end else if (scl_fall) begin
					if (ackd_q) begin
						ptr_d = 8'(ptr_q + 8'h01);
						rd_tgl_d = ~rd_tgl_q;
						st_d = ccr_pkg::ST_FETCH;
					end else begin
						st_d = ccr_pkg::ST_IDLE;
					end
				end
			end
			default: st_d = ccr_pkg::ST_IDLE;
		endcase
		if (bus_stop) begin
			st_d = ccr_pkg::ST_IDLE;
		end
		if (bus_start) begin
			st_d = ccr_pkg::ST_RX;
			ph_d = ccr_pkg::PH_ADDR;
			cnt_d = 4'h0;
		end
	end

	// Register the link state and the returning acknowledge toggle
	always_ff @(posedge lclk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= ccr_pkg::ST_IDLE;
			ph_q <= ccr_pkg::PH_ADDR;
			cnt_q <= 4'h0;
			sr_q <= 8'h00;
			ptr_q <= 8'h00;
			rw_q <= 1'b0;
			ackd_q <= 1'b0;
			wr_tgl_q <= 1'b0;
			rd_tgl_q <= 1'b0;
			wr_addr_q <= 8'h00;
			wr_data_q <= 8'h00;
			rdack_sy_q <= 2'h0;
			rdack_p_q <= 1'b0;
			ld_q <= 1'b0;
		end else begin
			st_q <= st_d;
			ph_q <= ph_d;
			cnt_q <= cnt_d;
			sr_q <= sr_d;
			ptr_q <= ptr_d;
			rw_q <= rw_d;
			ackd_q <= ackd_d;
			wr_tgl_q <= wr_tgl_d;
			rd_tgl_q <= rd_tgl_d;
			wr_addr_q <= wr_addr_d;
			wr_data_q <= wr_data_d;
			rdack_sy_q <= {rdack_sy_q[0], rdack_tgl_q};
			rdack_p_q <= rdack_sy_q[1];
			ld_q <= ld_d;
		end
	end

	// Open-drain drive: only ever pull low
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = (st_q == ccr_pkg::ST_FETCH);
	assign sda_oe = (st_q == ccr_pkg::ST_ACK) ||
		((st_q == ccr_pkg::ST_TX || (st_q == ccr_pkg::ST_FETCH && ld_q)) && !sr_q[7]);

	// =========================================================
	// Core domain: crossing, register bank, watchdog
	logic [1:0] wr_sy_q, rd_sy_q, ppl_sy_q;
	logic wr_p_q, rd_p_q, wr_ev, rd_ev;
	logic [7:0] regs_q [1:5];
	logic [7:0] regs_d [1:5];
	logic kick_q, kick_d, fault_q, fault_d;
	logic [27:0] sec_cnt_q, sec_cnt_d;
	logic [7:0] wd_sec_q, wd_sec_d, wd_period;
	ccr_pkg::cfg_t cfg_q, cfg_d;

	// Toggle events; the link holds address and data until the next toggle
	assign wr_ev = wr_sy_q[1] ^ wr_p_q;
	assign rd_ev = rd_sy_q[1] ^ rd_p_q;
	assign wd_period = wdog_secs(regs_q[5][ccr_pkg::WDOG_HI:ccr_pkg::WDOG_LO]);

	// Bank writes, read answers and the watchdog count
	always_comb begin
		regs_d = regs_q;
		kick_d = 1'b0;
		rd_data_d = rd_data_q;
		rdack_tgl_d = rdack_tgl_q;
		sec_cnt_d = 28'(sec_cnt_q + 28'h0000001);
		wd_sec_d = wd_sec_q;
		fault_d = fault_q & ~kick_q;
		if (wr_ev) begin
			if (wr_addr_q == ccr_pkg::ADDR_PWR_ON && wr_data_q[ccr_pkg::REG_RESET_BIT]) begin
				regs_d[1] = ccr_pkg::RST_PWR_ON;
				regs_d[2] = ccr_pkg::RST_CHG_CUR;
				regs_d[3] = ccr_pkg::RST_PRE_TERM;
				regs_d[4] = ccr_pkg::RST_CHG_VOLT;
				regs_d[5] = ccr_pkg::RST_TERM_TMR;
			end else begin
				unique case (wr_addr_q)
					ccr_pkg::ADDR_PWR_ON: begin
						regs_d[1] = wr_data_q & ccr_pkg::PWR_ON_STORE_MASK;
						kick_d = wr_data_q[ccr_pkg::WDOG_KICK_BIT];
					end
					ccr_pkg::ADDR_CHG_CUR: regs_d[2] = wr_data_q;
					ccr_pkg::ADDR_PRE_TERM: regs_d[3] = wr_data_q;
					ccr_pkg::ADDR_CHG_VOLT: regs_d[4] = wr_data_q;
					ccr_pkg::ADDR_TERM_TMR: regs_d[5] = wr_data_q & ccr_pkg::TERM_TMR_STORE_MASK;
					default: begin
					end
				endcase
			end
		end
		if (rd_ev) begin
			rdack_tgl_d = ~rdack_tgl_q;
			if (ptr_q >= ccr_pkg::ADDR_PWR_ON && ptr_q <= ccr_pkg::ADDR_TERM_TMR) begin
				rd_data_d = regs_q[ptr_q[2:0]];
			end else begin
				rd_data_d = 8'h00;
			end
		end
		// Expiry is judged before a restart, so a restart on the expiry
		// cycle cannot hide the fault: the set wins over the clear
		if (wd_period == 8'h00) begin
			sec_cnt_d = 28'h0000000;
			wd_sec_d = 8'h00;
		end else if (sec_cnt_q == 28'(SEC_CYCLES - 1)) begin
			sec_cnt_d = 28'h0000000;
			wd_sec_d = 8'(wd_sec_q + 8'h01);
			if (8'(wd_sec_q + 8'h01) >= wd_period) begin
				wd_sec_d = 8'h00;
				fault_d = 1'b1;
			end
		end
		if (kick_q) begin
			sec_cnt_d = 28'h0000000;
			wd_sec_d = 8'h00;
		end
	end

	// Decoded settings for the analog loops
	always_comb begin
		cfg_d.charge_enable = regs_q[1][ccr_pkg::MODE_HI:ccr_pkg::MODE_LO] == ccr_pkg::MODE_CHARGE;
		cfg_d.otg_enable = regs_q[1][ccr_pkg::MODE_HI];
		cfg_d.min_system_voltage = lin({3'h0, regs_q[1][ccr_pkg::VSYS_HI:ccr_pkg::VSYS_LO]},
			ccr_pkg::VSYS_STEP, ccr_pkg::VSYS_OFS);
		cfg_d.system_headroom_select = regs_q[1][ccr_pkg::HEADROOM_BIT];
		cfg_d.fast_charge_current = lin(regs_q[2][ccr_pkg::ICHG_HI:ccr_pkg::ICHG_LO],
			ccr_pkg::I64_STEP, ccr_pkg::ICHG_OFS);
		cfg_d.boost_output_current_limit =
			regs_q[2][ccr_pkg::OLIM_HI:ccr_pkg::OLIM_LO] != ccr_pkg::OLIM_500MA;
		cfg_d.precharge_current = lin({2'h0, regs_q[3][ccr_pkg::IPRE_HI:ccr_pkg::IPRE_LO]},
			ccr_pkg::I64_STEP, ccr_pkg::I64_OFS);
		cfg_d.termination_current = lin({2'h0, regs_q[3][ccr_pkg::IBF_HI:ccr_pkg::IBF_LO]},
			ccr_pkg::I64_STEP, ccr_pkg::I64_OFS);
		cfg_d.full_charge_voltage = lin(regs_q[4][ccr_pkg::VFULL_HI:ccr_pkg::VFULL_LO],
			ccr_pkg::VFULL_STEP, ccr_pkg::VFULL_OFS);
		cfg_d.precharge_exit_threshold = regs_q[4][ccr_pkg::VPRE_BIT];
		cfg_d.recharge_offset = regs_q[4][ccr_pkg::VRECH_BIT];
		cfg_d.termination_enable = regs_q[5][ccr_pkg::TERM_EN_BIT];
		cfg_d.done_indicator_early = regs_q[5][ccr_pkg::DONE_EARLY_BIT];
		cfg_d.safety_timer_enable = regs_q[5][ccr_pkg::TMR_EN_BIT];
		unique case (regs_q[5][ccr_pkg::TMR_HI:ccr_pkg::TMR_LO])
			2'h0: cfg_d.cc_timer_select = ccr_pkg::TMR_H_0;
			2'h1: cfg_d.cc_timer_select = ccr_pkg::TMR_H_1;
			2'h2: cfg_d.cc_timer_select = ccr_pkg::TMR_H_2;
			default: cfg_d.cc_timer_select = ccr_pkg::TMR_H_3;
		endcase
		if (ppl_sy_q[1]) begin
			cfg_d.cc_timer_select = {cfg_d.cc_timer_select[4:0], 1'b0};
		end
	end

	// Core registers; the bank resets to its defaults
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			regs_q[1] <= ccr_pkg::RST_PWR_ON;
			regs_q[2] <= ccr_pkg::RST_CHG_CUR;
			regs_q[3] <= ccr_pkg::RST_PRE_TERM;
			regs_q[4] <= ccr_pkg::RST_CHG_VOLT;
			regs_q[5] <= ccr_pkg::RST_TERM_TMR;
			wr_sy_q <= 2'h0;
			rd_sy_q <= 2'h0;
			ppl_sy_q <= 2'h0;
			wr_p_q <= 1'b0;
			rd_p_q <= 1'b0;
			kick_q <= 1'b0;
			fault_q <= 1'b0;
			rd_data_q <= 8'h00;
			rdack_tgl_q <= 1'b0;
			sec_cnt_q <= 28'h0000000;
			wd_sec_q <= 8'h00;
			cfg_q <= '0;
		end else begin
			regs_q <= regs_d;
			wr_sy_q <= {wr_sy_q[0], wr_tgl_q};
			rd_sy_q <= {rd_sy_q[0], rd_tgl_q};
			ppl_sy_q <= {ppl_sy_q[0], power_path_limiting};
			wr_p_q <= wr_sy_q[1];
			rd_p_q <= rd_sy_q[1];
			kick_q <= kick_d;
			fault_q <= fault_d;
			rd_data_q <= rd_data_d;
			rdack_tgl_q <= rdack_tgl_d;
			sec_cnt_q <= sec_cnt_d;
			wd_sec_q <= wd_sec_d;
			cfg_q <= cfg_d;
		end
	end

	assign cfg = cfg_q;
	assign wdog_fault = fault_q;
endmodule : ccr_charger_config_registers

// file: verilog/ccr_pkg.sv
// Constants, field layout and types for the charger configuration bank.
// Assumes a 250 MHz core clock and an open-drain two-wire serial port.
package ccr_pkg;
	// =========================================================
	// Serial port addressing
	localparam logic [6:0] DEV_ADDR = 7'h4B;
	localparam logic [7:0] ADDR_PWR_ON = 8'h01;
	localparam logic [7:0] ADDR_CHG_CUR = 8'h02;
	localparam logic [7:0] ADDR_PRE_TERM = 8'h03;
	localparam logic [7:0] ADDR_CHG_VOLT = 8'h04;
	localparam logic [7:0] ADDR_TERM_TMR = 8'h05;
	localparam logic [7:0] ADDR_LAST_DEF = 8'h0A;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// =========================================================
	// Reset values and write masks
	localparam logic [7:0] RST_PWR_ON = 8'h1B;
	localparam logic [7:0] RST_CHG_CUR = 8'h21;
	localparam logic [7:0] RST_PRE_TERM = 8'h33;
	localparam logic [7:0] RST_CHG_VOLT = 8'hC3;
	localparam logic [7:0] RST_TERM_TMR = 8'h98;
	localparam logic [7:0] PWR_ON_STORE_MASK = 8'h3F;
	localparam logic [7:0] TERM_TMR_STORE_MASK = 8'hFE;
	// =========================================================
	// Field positions
	localparam int REG_RESET_BIT = 7;
	localparam int WDOG_KICK_BIT = 6;
	localparam int MODE_HI = 5, MODE_LO = 4;
	localparam int VSYS_HI = 3, VSYS_LO = 1;
	localparam int HEADROOM_BIT = 0;
	localparam int ICHG_HI = 7, ICHG_LO = 2;
	localparam int OLIM_HI = 1, OLIM_LO = 0;
	localparam int IPRE_HI = 7, IPRE_LO = 4;
	localparam int IBF_HI = 3, IBF_LO = 0;
	localparam int VFULL_HI = 7, VFULL_LO = 2;
	localparam int VPRE_BIT = 1, VRECH_BIT = 0;
	localparam int TERM_EN_BIT = 7, DONE_EARLY_BIT = 6;
	localparam int WDOG_HI = 5, WDOG_LO = 4;
	localparam int TMR_EN_BIT = 3;
	localparam int TMR_HI = 2, TMR_LO = 1;
	// =========================================================
	// Codes and scales (mV, mA, seconds or hours)
	localparam logic [1:0] MODE_OFF = 2'h0, MODE_CHARGE = 2'h1;
	localparam logic [1:0] OLIM_500MA = 2'h0;
	localparam logic [12:0] VSYS_OFS = 13'h0BB8;
	localparam logic [7:0] VSYS_STEP = 8'h64;
	localparam logic [12:0] ICHG_OFS = 13'h0200;
	localparam logic [12:0] I64_OFS = 13'h0040;
	localparam logic [7:0] I64_STEP = 8'h40;
	localparam logic [12:0] VFULL_OFS = 13'h0D98;
	localparam logic [7:0] VFULL_STEP = 8'h0F;
	localparam logic [7:0] WDOG_S_1 = 8'h28, WDOG_S_2 = 8'h50, WDOG_S_3 = 8'hA0;
	localparam logic [5:0] TMR_H_0 = 6'h05, TMR_H_1 = 6'h08;
	localparam logic [5:0] TMR_H_2 = 6'h0C, TMR_H_3 = 6'h14;
	// =========================================================
	// Timing: one watchdog tick is one second of core clock
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned WDOG_TICK_S = 1;
	localparam int unsigned SEC_CYCLES_DEF = WDOG_TICK_S * CLK_MHZ * 1000000;
	// =========================================================
	// Types
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01, ST_RX = 6'h02, ST_ACK = 6'h04,
		ST_FETCH = 6'h08, ST_TX = 6'h10, ST_MACK = 6'h20
	} st_t;
	typedef enum logic [1:0] {PH_ADDR = 2'h0, PH_REG = 2'h1, PH_DATA = 2'h2} ph_t;
	typedef struct packed {
		logic charge_enable;
		logic otg_enable;
		logic [12:0] min_system_voltage;
		logic system_headroom_select;
		logic [12:0] fast_charge_current;
		logic boost_output_current_limit;
		logic [12:0] precharge_current;
		logic [12:0] termination_current;
		logic [12:0] full_charge_voltage;
		logic precharge_exit_threshold;
		logic recharge_offset;
		logic termination_enable;
		logic done_indicator_early;
		logic safety_timer_enable;
		logic [5:0] cc_timer_select;
	} cfg_t;
endpackage : ccr_pkg
